// *** sfp_protect.sv ***
`timescale 1ns/10ps
module sfp_protect
    import sfp_pkg::*;
#(
    parameter int RESTART_CYC = AUTO_RESTART_CYC
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    // AXI4-Lite write
    input  wire logic [7:0]        axi_awaddr_in,
    input  wire logic              axi_awvalid_in,
    output logic                   axi_awready_out,
    input  wire logic [31:0]       axi_wdata_in,
    input  wire logic [3:0]        axi_wstrb_in,
    input  wire logic              axi_wvalid_in,
    output logic                   axi_wready_out,
    output logic [1:0]             axi_bresp_out,
    output logic                   axi_bvalid_out,
    input  wire logic              axi_bready_in,
    // AXI4-Lite read
    input  wire logic [7:0]        axi_araddr_in,
    input  wire logic              axi_arvalid_in,
    output logic                   axi_arready_out,
    output logic [31:0]            axi_rdata_out,
    output logic [1:0]             axi_rresp_out,
    output logic                   axi_rvalid_out,
    input  wire logic              axi_rready_in,
    // Supply monitor pins
    input  wire logic              supply_low_raw_in,
    input  wire logic              supply_high_raw_in,
    input  wire logic              pump_bad_raw_in,
    // Mode
    input  wire logic              fail_mode_in,
    // Outputs
    output logic [NUM_CH-1:0]      power_out_en_out,
    output logic [NUM_CH-1:0]      inrush_window_start_out,
    output logic                   device_fault_summary_flag_out,
    output logic                   irq_out
);
    logic                  rst_meta;
    logic                  rst_n;
    sfp_fault_s            raw_flt;
    sfp_fault_s            sync_flt;
    logic [NUM_FLT-1:0]    flt;
    logic                  low_flt;
    logic                  high_flt;
    logic                  pump_flt;

    sfp_wr_e               wr_state;
    sfp_wr_e               next_wr_state;
    sfp_rd_e               rd_state;
    sfp_rd_e               next_rd_state;
    logic                  aw_got;
    logic                  next_aw_got;
    logic                  w_got;
    logic                  next_w_got;
    logic [7:0]            awaddr;
    logic [7:0]            next_awaddr;
    logic [31:0]           wdata;
    logic [31:0]           next_wdata;
    logic [3:0]            wstrb;
    logic [3:0]            next_wstrb;
    logic [1:0]            next_bresp;
    logic [31:0]           next_rdata;
    logic [1:0]            next_rresp;
    logic                  wr_fire;
    logic                  rd_fire;
    logic [31:0]           rd_val;

    logic [NUM_CH-1:0]     cmd_on;
    logic [NUM_CH-1:0]     next_cmd_on;
    logic [NUM_CH-1:0]     next_out_en;
    logic [NUM_CH-1:0]     next_inrush;
    logic                  supply_low_flag;
    logic                  next_supply_low_flag;
    logic                  supply_high_flag;
    logic                  next_supply_high_flag;
    logic                  pump_fault_flag;
    logic                  next_pump_fault_flag;
    logic                  powering_up;
    logic                  next_powering_up;
    logic [1:0]            sync_fill;
    logic [1:0]            next_sync_fill;
    logic                  restart_wait;
    logic                  next_restart_wait;
    logic [RESTART_W-1:0]  restart_cnt;
    logic [RESTART_W-1:0]  next_restart_cnt;
    logic [NUM_FLT-1:0]    irq_stat;
    logic [NUM_FLT-1:0]    next_irq_stat;
    logic [NUM_FLT-1:0]    irq_en;
    logic [NUM_FLT-1:0]    next_irq_en;
    logic [NUM_FLT-1:0]    irq_clr;
    logic                  on_wr_ok;
    logic                  rd_quick;
    logic                  rd_device;
    logic                  block;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign raw_flt = '{low: supply_low_raw_in, high: supply_high_raw_in,
                       pump: pump_bad_raw_in};

    sfp_sync2 #(.W(NUM_FLT)) u_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n),
        .d_in     (raw_flt),
        .q_out    (sync_flt)
    );

    generate
        for (genvar i = 0; i < NUM_FLT; i++) begin : g_dgl
            sfp_deglitch #(.CYCLES(i == 0 ? CP_DGL_CYC : UV_OV_DGL_CYC)) u_dgl (
                .clock_in (clock_in),
                .rst_n_in (rst_n),
                .raw_in   (sync_flt[i]),
                .flt_out  (flt[i])
            );
        end
    endgenerate

    assign pump_flt = flt[0];
    assign high_flt = flt[1];
    assign low_flt  = flt[2];

    // Register bus
    assign axi_awready_out = (wr_state == WR_IDLE) && !aw_got;
    assign axi_wready_out  = (wr_state == WR_IDLE) && !w_got;
    assign axi_bvalid_out  = (wr_state == WR_RESP);
    assign axi_arready_out = (rd_state == RD_IDLE);
    assign axi_rvalid_out  = (rd_state == RD_DATA);
    assign wr_fire         = (wr_state == WR_IDLE) && aw_got && w_got;
    assign rd_fire         = axi_arvalid_in && axi_arready_out;

    always_comb begin
        rd_val = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (axi_araddr_in == ADDR_CH1 + 8'(ADDR_STEP * i)) begin
                rd_val[CH_ON_BIT] = cmd_on[i];
            end
        end
        case (axi_araddr_in)
            ADDR_QUICK: begin
                rd_val[QS_PUMP] = pump_fault_flag;
                rd_val[QS_DSF]  = device_fault_summary_flag_out;
            end
            ADDR_DEVICE: begin
                rd_val[DS_LOW]  = supply_low_flag;
                rd_val[DS_HIGH] = supply_high_flag;
                rd_val[DS_DSF]  = device_fault_summary_flag_out;
            end
            ADDR_OUTCTRL:  rd_val[NUM_CH-1:0] = cmd_on;
            ADDR_IRQ_STAT: rd_val[NUM_FLT-1:0] = irq_stat;
            ADDR_IRQ_EN:   rd_val[NUM_FLT-1:0] = irq_en;
            ADDR_LIVE: begin
                rd_val[NUM_CH-1:0] = power_out_en_out;
                rd_val[LIVE_PWRUP] = powering_up;
                rd_val[LIVE_WAIT]  = restart_wait;
                rd_val[LIVE_DSF]   = device_fault_summary_flag_out;
            end
            default: rd_val = rd_val;
        endcase
    end

    always_comb begin
        next_wr_state = wr_state;
        next_aw_got   = aw_got;
        next_w_got    = w_got;
        next_awaddr   = awaddr;
        next_wdata    = wdata;
        next_wstrb    = wstrb;
        next_bresp    = axi_bresp_out;
        next_rd_state = rd_state;
        next_rdata    = axi_rdata_out;
        next_rresp    = axi_rresp_out;
        case (wr_state)
            WR_IDLE: begin
                if (axi_awvalid_in && !aw_got) begin
                    next_aw_got = 1'b1;
                    next_awaddr = axi_awaddr_in;
                end
                if (axi_wvalid_in && !w_got) begin
                    next_w_got = 1'b1;
                    next_wdata = axi_wdata_in;
                    next_wstrb = axi_wstrb_in;
                end
                if (wr_fire) begin
                    next_aw_got   = 1'b0;
                    next_w_got    = 1'b0;
                    next_wr_state = WR_RESP;
                    next_bresp    = (awaddr <= ADDR_LIVE && awaddr[1:0] == 2'h0)
                                    ? RESP_OKAY : RESP_SLVERR;
                end
            end
            WR_RESP: begin
                if (axi_bready_in) begin
                    next_wr_state = WR_IDLE;
                end
            end
            default: next_wr_state = WR_IDLE;
        endcase
        case (rd_state)
            RD_IDLE: begin
                if (rd_fire) begin
                    next_rd_state = RD_DATA;
                    next_rdata    = rd_val;
                    next_rresp    = (axi_araddr_in <= ADDR_LIVE && axi_araddr_in[1:0] == 2'h0)
                                    ? RESP_OKAY : RESP_SLVERR;
                end
            end
            RD_DATA: begin
                if (axi_rready_in) begin
                    next_rd_state = RD_IDLE;
                end
            end
            default: next_rd_state = RD_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_state      <= WR_IDLE;
            rd_state      <= RD_IDLE;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            awaddr        <= '0;
            wdata         <= '0;
            wstrb         <= '0;
            axi_bresp_out <= RESP_OKAY;
            axi_rdata_out <= '0;
            axi_rresp_out <= RESP_OKAY;
        end else begin
            wr_state      <= next_wr_state;
            rd_state      <= next_rd_state;
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            awaddr        <= next_awaddr;
            wdata         <= next_wdata;
            wstrb         <= next_wstrb;
            axi_bresp_out <= next_bresp;
            axi_rdata_out <= next_rdata;
            axi_rresp_out <= next_rresp;
        end
    end

    // Protection and output control
    assign rd_quick  = rd_fire && axi_araddr_in == ADDR_QUICK;
    assign rd_device = rd_fire && axi_araddr_in == ADDR_DEVICE;
    assign on_wr_ok  = fail_mode_in || !low_flt;
    assign block     = low_flt || pump_flt || powering_up || restart_wait;
    assign irq_clr   = (wr_fire && awaddr == ADDR_IRQ_CLR && wstrb[0])
                       ? wdata[NUM_FLT-1:0] : '0;

    always_comb begin
        next_cmd_on = cmd_on;
        next_irq_en = irq_en;
        if (wr_fire && wstrb[0]) begin
            // Turn-on writes are refused while undervoltage stands in Normal mode
            if (awaddr == ADDR_OUTCTRL) begin
                next_cmd_on = wdata[NUM_CH-1:0] & (on_wr_ok ? {NUM_CH{1'b1}} : cmd_on);
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (awaddr == ADDR_CH1 + 8'(ADDR_STEP * i)) begin
                    next_cmd_on[i] = wdata[CH_ON_BIT] & (on_wr_ok | cmd_on[i]);
                end
            end
            if (awaddr == ADDR_IRQ_EN) begin
                next_irq_en = wdata[NUM_FLT-1:0];
            end
        end
        if (low_flt && !fail_mode_in) begin
            next_cmd_on = '0;
        end

        // Synchroniser shows its reset value for two edges after reset
        next_sync_fill   = {sync_fill[0], 1'b1};
        next_powering_up = powering_up && (sync_flt.pump || !sync_fill[1]);

        next_restart_wait = restart_wait;
        next_restart_cnt  = restart_cnt;
        if (low_flt) begin
            next_restart_wait = fail_mode_in;
            next_restart_cnt  = '0;
        end else if (restart_wait) begin
            if (restart_cnt == RESTART_W'(RESTART_CYC - 1)) begin
                next_restart_wait = 1'b0;
            end else begin
                next_restart_cnt = restart_cnt + 1'b1;
            end
        end

        next_out_en = block ? '0 : cmd_on;
        next_inrush = next_out_en & ~power_out_en_out;

        // Hardware set wins over a clearing read
        next_supply_low_flag  = low_flt | (supply_low_flag & !(rd_device && !low_flt));
        next_supply_high_flag = high_flt
                                | (supply_high_flag & !(rd_device && !high_flt));
        next_pump_fault_flag  = (pump_flt && !powering_up)
                                | (pump_fault_flag & !(rd_quick && !pump_flt));

        next_irq_stat = (irq_stat & ~irq_clr)
                        | {next_supply_low_flag & ~supply_low_flag,
                           next_supply_high_flag & ~supply_high_flag,
                           next_pump_fault_flag & ~pump_fault_flag};
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_on                  <= '0;
            power_out_en_out        <= '0;
            inrush_window_start_out <= '0;
            supply_low_flag         <= 1'b0;
            supply_high_flag        <= 1'b0;
            pump_fault_flag         <= 1'b0;
            powering_up             <= 1'b1;
            sync_fill               <= '0;
            restart_wait            <= 1'b0;
            restart_cnt             <= '0;
            irq_stat                <= '0;
            irq_en                  <= '0;
        end else begin
            cmd_on                  <= next_cmd_on;
            power_out_en_out        <= next_out_en;
            inrush_window_start_out <= next_inrush;
            supply_low_flag         <= next_supply_low_flag;
            supply_high_flag        <= next_supply_high_flag;
            pump_fault_flag         <= next_pump_fault_flag;
            powering_up             <= next_powering_up;
            sync_fill               <= next_sync_fill;
            restart_wait            <= next_restart_wait;
            restart_cnt             <= next_restart_cnt;
            irq_stat                <= next_irq_stat;
            irq_en                  <= next_irq_en;
        end
    end

    assign device_fault_summary_flag_out = supply_low_flag | supply_high_flag
                                           | pump_fault_flag;
    assign irq_out = |(irq_stat & irq_en);

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    a_uv_outputs_off: assert property (low_flt |=> power_out_en_out == '0)
        else $error("outputs on during undervoltage");
    a_uv_flag_set: assert property ($rose(low_flt) |=> supply_low_flag && device_fault_summary_flag_out)
        else $error("undervoltage not reported");
    a_uv_cmd_cleared: assert property (low_flt && !fail_mode_in |=> cmd_on == '0)
        else $error("command survived undervoltage in normal mode");
    a_supply_latch_hold: assert property (supply_low_flag && (low_flt || !rd_device) |=> supply_low_flag)
        else $error("supply-low flag cleared early");
    a_high_flag_set: assert property ($rose(high_flt) |=> supply_high_flag)
        else $error("overvoltage not reported");
    a_powerup_hold: assert property (powering_up |=> power_out_en_out == '0)
        else $error("output on before pump settled");
    a_pump_outputs_off: assert property (pump_flt |=> power_out_en_out == '0)
        else $error("outputs on during pump failure");
    a_pump_flag_set: assert property ($rose(pump_flt) && !powering_up |=> pump_fault_flag)
        else $error("pump failure not reported");
    a_inrush_start: assert property (inrush_window_start_out == (power_out_en_out & ~$past(power_out_en_out)))
        else $error("inrush window not started with output");
    a_pump_latch_hold: assert property (pump_fault_flag && (pump_flt || !rd_quick) |=> pump_fault_flag)
        else $error("pump flag cleared early");
    a_restart_release: assert property (fail_mode_in && $fell(restart_wait) && !low_flt && !pump_flt && !powering_up |=> power_out_en_out == $past(cmd_on))
        else $error("auto-restart did not restore outputs");
    a_summary_or: assert property (device_fault_summary_flag_out == (supply_low_flag | supply_high_flag | pump_fault_flag))
        else $error("summary flag mismatch");

    c_uv_event: cover property ($rose(supply_low_flag));
    c_pump_recover: cover property ($fell(pump_flt) ##[1:4] (inrush_window_start_out != '0));
    c_auto_restart: cover property (fail_mode_in && $fell(restart_wait));
    c_flag_clear: cover property ($fell(pump_fault_flag));
endmodule : sfp_protect

// *** sfp_pkg.sv ***
package sfp_pkg;
    localparam int CLK_MHZ          = 50;
    localparam int UV_OV_DGL_NS     = 3500;
    localparam int CP_DGL_NS        = 4000;
    localparam int AUTO_RESTART_US  = 64000;
    localparam int UV_OV_DGL_CYC    = UV_OV_DGL_NS * CLK_MHZ / 1000;
    localparam int CP_DGL_CYC       = CP_DGL_NS * CLK_MHZ / 1000;
    localparam int AUTO_RESTART_CYC = AUTO_RESTART_US * CLK_MHZ;
    localparam int NUM_CH           = 5;
    localparam int NUM_FLT          = 3;
    localparam int RESTART_W        = 22;

    localparam logic [7:0] ADDR_QUICK    = 8'h00;
    localparam logic [7:0] ADDR_DEVICE   = 8'h04;
    localparam logic [7:0] ADDR_OUTCTRL  = 8'h08;
    localparam logic [7:0] ADDR_CH1      = 8'h0C;
    localparam logic [7:0] ADDR_STEP     = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h28;
    localparam logic [7:0] ADDR_LIVE     = 8'h2C;

    localparam int QS_PUMP    = 0;
    localparam int QS_DSF     = 1;
    localparam int DS_LOW     = 0;
    localparam int DS_HIGH    = 1;
    localparam int DS_DSF     = 2;
    localparam int CH_ON_BIT  = 0;
    localparam int LIVE_PWRUP = 5;
    localparam int LIVE_WAIT  = 6;
    localparam int LIVE_DSF   = 7;

    // Fault vector order: pump at bit 0, high at bit 1, low at bit 2
    typedef struct packed {
        logic low;
        logic high;
        logic pump;
    } sfp_fault_s;

    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} sfp_wr_e;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} sfp_rd_e;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sfp_pkg

// *** sfp_sync2.sv ***
`timescale 1ns/10ps
module sfp_sync2 #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         clock_in,
    input  wire logic         rst_n_in,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : sfp_sync2

// *** sfp_deglitch.sv ***
`timescale 1ns/10ps
module sfp_deglitch #(
    parameter int CYCLES = 175
) (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    // Filter
    input  wire logic raw_in,
    output logic      flt_out
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_flt;

    // Assertion needs the level to persist; removal clears at once
    always_comb begin
        next_cnt = cnt;
        next_flt = flt_out;
        if (!raw_in) begin
            next_cnt = '0;
            next_flt = 1'b0;
        end else if (cnt == CW'(CYCLES - 1)) begin
            next_flt = 1'b1;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt     <= '0;
            flt_out <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            flt_out <= next_flt;
        end
    end

    a_dgl_full_count: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(flt_out) |-> $past(cnt) == CW'(CYCLES - 1) && $past(raw_in))
        else $error("fault raised before the deglitch count completed");
endmodule : sfp_deglitch

// *** sfp_host_model.sv ***
`timescale 1ns/10ps
module sfp_host_model (
    // Clock
    input  wire logic        clock_in,
    // Write channels
    output logic [7:0]       aw_out,
    output logic             awv_out,
    input  wire logic        awr_in,
    output logic [31:0]      wd_out,
    output logic             wv_out,
    input  wire logic        wr_in,
    input  wire logic        bv_in,
    input  wire logic [1:0]  bresp_in,
    output logic             br_out,
    // Read channels
    output logic [7:0]       ar_out,
    output logic             arv_out,
    input  wire logic        arr_in,
    input  wire logic        rv_in,
    input  wire logic [1:0]  rresp_in,
    input  wire logic [31:0] rd_in,
    output logic             rr_out,
    // Stuck handshake
    output logic             hang_out
);
    initial begin
        {aw_out, awv_out, wd_out, wv_out, br_out} = '0;
        {ar_out, arv_out, rr_out, hang_out} = '0;
    end

    // Handshakes are judged on the values that stand just before the edge
    task automatic put(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ka, kw, kb;
        @(posedge clock_in);
        aw_out  <= a;
        wd_out  <= d;
        awv_out <= 1'b1;
        wv_out  <= 1'b1;
        br_out  <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clock_in);
            {ka, kw, kb, r} = {awv_out & awr_in, wv_out & wr_in, bv_in, bresp_in};
            @(posedge clock_in);
            if (ka) awv_out <= 1'b0;
            if (kw) wv_out <= 1'b0;
            if (kb) begin
                br_out <= 1'b0;
                return;
            end
        end
        hang_out <= 1'b1;
    endtask : put

    task automatic get(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ka, kr;
        @(posedge clock_in);
        ar_out  <= a;
        arv_out <= 1'b1;
        rr_out  <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clock_in);
            {ka, kr, d, r} = {arv_out & arr_in, rv_in, rd_in, rresp_in};
            @(posedge clock_in);
            if (ka) arv_out <= 1'b0;
            if (kr) begin
                rr_out <= 1'b0;
                return;
            end
        end
        hang_out <= 1'b1;
    endtask : get
endmodule : sfp_host_model

// *** supply_fault_protection_tb.sv ***
`timescale 1ns/10ps
module supply_fault_protection_tb;
    import sfp_pkg::*;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, hang;
    logic [7:0]  axi_awaddr_in, axi_araddr_in;
    logic [31:0] axi_wdata_in, axi_rdata_out, d;
    logic [1:0]  axi_bresp_out, axi_rresp_out, r;
    logic        axi_awvalid_in, axi_awready_out, axi_wvalid_in, axi_wready_out;
    logic        axi_bvalid_out, axi_bready_in, axi_arvalid_in, axi_arready_out;
    logic        axi_rvalid_out, axi_rready_in, fail_mode_in, irq_out;
    logic        supply_low_raw_in, supply_high_raw_in, pump_bad_raw_in;
    logic        device_fault_summary_flag_out;
    logic [4:0]  power_out_en_out, inrush_window_start_out;
    int          err_total = 0, checked = 0, k;

    always #10 clock_in = ~clock_in;

    sfp_protect #(.RESTART_CYC(20)) sfp_protect_inst (
        .clock_in, .rst_n_in, .axi_awaddr_in, .axi_awvalid_in, .axi_awready_out,
        .axi_wdata_in, .axi_wstrb_in(4'hF), .axi_wvalid_in, .axi_wready_out,
        .axi_bresp_out, .axi_bvalid_out, .axi_bready_in, .axi_araddr_in,
        .axi_arvalid_in, .axi_arready_out, .axi_rdata_out, .axi_rresp_out,
        .axi_rvalid_out, .axi_rready_in, .supply_low_raw_in, .supply_high_raw_in,
        .pump_bad_raw_in, .fail_mode_in, .power_out_en_out, .inrush_window_start_out,
        .device_fault_summary_flag_out, .irq_out
    );

    sfp_host_model sfp_host_model_inst (
        .clock_in, .aw_out(axi_awaddr_in), .awv_out(axi_awvalid_in),
        .awr_in(axi_awready_out), .wd_out(axi_wdata_in), .wv_out(axi_wvalid_in),
        .wr_in(axi_wready_out), .bv_in(axi_bvalid_out), .bresp_in(axi_bresp_out),
        .br_out(axi_bready_in), .ar_out(axi_araddr_in), .arv_out(axi_arvalid_in),
        .arr_in(axi_arready_out), .rv_in(axi_rvalid_out), .rresp_in(axi_rresp_out),
        .rd_in(axi_rdata_out), .rr_out(axi_rready_in), .hang_out(hang)
    );

    function automatic logic [4:0] on_bit(input int c);
        return 5'h01 << c;
    endfunction : on_bit

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        sfp_host_model_inst.put(a, v, r);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        sfp_host_model_inst.get(a, d, r);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask : cyc

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        #1;
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic finish_test;
        if (hang === 1'b1) err_total++;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial begin
        cyc(60000);
        err_total++;
        finish_test;
    end

    initial begin
        void'($urandom(32'h4BBD988B));
        {fail_mode_in, supply_low_raw_in, supply_high_raw_in} <= 3'h0;
        pump_bad_raw_in <= 1'b1;
        cyc(10);
        rst_n_in <= 1'b1;
        cyc(3);
        wr(ADDR_OUTCTRL, 32'h1F);
        cyc(5);
        chk(power_out_en_out, 0);
        pump_bad_raw_in <= 1'b0;
        cyc(6);
        chk(power_out_en_out, 5'h1F);
        chk(device_fault_summary_flag_out, 0);
        supply_low_raw_in <= 1'b1;
        cyc(UV_OV_DGL_CYC - 20);
        supply_low_raw_in <= 1'b0;
        cyc(5);
        chk(power_out_en_out, 5'h1F);
        supply_low_raw_in <= 1'b1;
        cyc(UV_OV_DGL_CYC + 6);
        chk(power_out_en_out, 0);
        chk(device_fault_summary_flag_out, 1);
        rd(ADDR_DEVICE);
        chk(d[2:0], 3'h5);
        k = $urandom_range(4);
        wr(ADDR_CH1 + 8'(4 * k), 32'h1);
        supply_low_raw_in <= 1'b0;
        cyc(6);
        chk(power_out_en_out, 0);
        rd(ADDR_DEVICE);
        chk(d[0], 1);
        chk(device_fault_summary_flag_out, 0);
        wr(ADDR_CH1 + 8'(4 * k), 32'h1);
        cyc(3);
        chk(power_out_en_out, on_bit(k));
        d = $urandom;
        wr(ADDR_OUTCTRL, d);
        chk(r, RESP_OKAY);
        cyc(3);
        chk(power_out_en_out, d[4:0]);
        wr(ADDR_IRQ_EN, 32'h2);
        supply_high_raw_in <= 1'b1;
        cyc(UV_OV_DGL_CYC + 6);
        chk(irq_out, 1);
        rd(ADDR_DEVICE);
        chk(d[2:0], 3'h6);
        supply_high_raw_in <= 1'b0;
        cyc(6);
        rd(ADDR_DEVICE);
        chk(d[1], 1);
        wr(ADDR_IRQ_CLR, 32'h2);
        cyc(2);
        chk(irq_out, 0);
        chk(device_fault_summary_flag_out, 0);
        pump_bad_raw_in <= 1'b1;
        cyc(CP_DGL_CYC + 6);
        chk(power_out_en_out, 0);
        chk(irq_out, 0);
        wr(ADDR_OUTCTRL, 32'h1F);
        rd(ADDR_QUICK);
        chk(d[1:0], 2'h3);
        pump_bad_raw_in <= 1'b0;
        for (int n = 0; n < 20 && inrush_window_start_out === 5'h00; n++) @(negedge clock_in);
        chk(inrush_window_start_out, 5'h1F);
        chk(power_out_en_out, 5'h1F);
        rd(ADDR_QUICK);
        chk(d[0], 1);
        chk(device_fault_summary_flag_out, 0);
        fail_mode_in <= 1'b1;
        supply_low_raw_in <= 1'b1;
        cyc(UV_OV_DGL_CYC + 6);
        chk(power_out_en_out, 0);
        supply_low_raw_in <= 1'b0;
        cyc(8);
        chk(power_out_en_out, 0);
        cyc(30);
        chk(power_out_en_out, 5'h1F);
        rd(ADDR_LIVE);
        chk(d[7:0], 8'h9F);
        rd(ADDR_IRQ_STAT);
        chk(d[2:0], 3'h5);
        rd(8'h40);
        chk(r, RESP_SLVERR);
        chk(d, 0);
        finish_test;
    end
endmodule : supply_fault_protection_tb
